// ==== rtl/tnm_alarm_monitor.sv ====
// Network-side alarm monitor: alarm events, error-rate detector and
// dedicated management channel time slot keeper.
// Assumes condition levels and CRC error pulses come from the framer,
// synchronous to i_mclk; configuration arrives as plain ports.
`timescale 1ns/1ps
// How it works
// - Loss-of-signal onset raises an event only while its enable is set.
// - Out-of-frame onset raises an event only while its enable is set.
// - All-ones alarm signal onset raises an event only when enabled.
// - Remote yellow alarm onset raises an event only when enabled.
// - Excess error rate becoming declared raises an event when enabled.
// - All five alarm enables, yellow and excess error included, reset to enabled.
// - Error-rate detection and reporting run only under extended superframe.
// - CRC-6 errors counted per period and compared with threshold limits.
// - Strictest: declare above 1535 per 10 s, clear below 1536.
// - Next: above 921 per 60 s or stricter level; clear below 922.
// - Next: above 92 per 60 s or stricter level; clear below 93.
// - Next: above 9 per 60 s or stricter level; clear below 10.
// - Next: above 41 over three 15-minute intervals or stricter level.
// - Loosest: above 4 over three 15-minute intervals or stricter level.
// - Management channel time slot held, limited to 1 through 24.
// - Only a free slot is accepted; default is lowest free slot.
// - Slot unassigned whenever the link is not the dedicated channel.
module tnm_alarm_monitor
  import tnm_pkg::*;
#(
  parameter int TICK_N  = tnm_pkg::TICK_CYC,
  parameter int SHORT_S = tnm_pkg::PER_SHORT_S,
  parameter int LONG_S  = tnm_pkg::PER_LONG_S,
  parameter int INTV_S  = tnm_pkg::PER_INTV_S
) (
  input  wire logic                               i_mclk,
  input  wire logic                               i_sys_rst,
  input  wire logic                               i_ce,
  input  wire logic                               i_los,
  input  wire logic                               i_oof,
  input  wire logic                               i_ais,
  input  wire logic                               i_yellow,
  input  wire logic                               i_crc_err,
  input  wire logic                               i_esf,
  input  wire logic                               i_cfg_wr,
  input  wire logic [tnm_pkg::ALM_N-1:0]          i_alarm_en,
  input  wire tnm_pkg::tnm_thr_e                  i_thresh,
  input  wire tnm_pkg::tnm_link_e                 i_mgmt_link,
  input  wire logic                               i_slot_wr,
  input  wire logic [tnm_pkg::SLOT_W-1:0]         i_slot_req,
  input  wire logic [tnm_pkg::NUM_SLOTS-1:0]      i_slot_busy,
  output logic [tnm_pkg::ALM_N-1:0]               o_alarm_evt,
  output logic [tnm_pkg::ALM_N-1:0]               o_alarm_en,
  output tnm_pkg::tnm_thr_e                       o_thresh,
  output logic                                    o_excess_error_rate_cond,
  output logic [tnm_pkg::SLOT_W-1:0]              o_dedicated_mgmt_channel_slot,
  output logic                                    o_slot_rej,
  output logic                                    o_tick
);
  import tnm_pkg::*;

  localparam int TW = $clog2(TICK_N);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_N - 1);
  localparam int SUM_W = CNT_W + 2;

  // One-second tick
  logic [TW-1:0] tick_cnt_q;
  logic          tick_now;

  assign tick_now = (tick_cnt_q == TICK_LAST);

  // A free-running count keeps every period an exact number of ticks
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      tick_cnt_q <= '0;
      o_tick     <= 1'b0;
    end
    else if (i_ce)
    begin
      tick_cnt_q <= tick_now ? '0 : tick_cnt_q + TW'(1);
      o_tick     <= tick_now;
    end
  end

  // Error windows, held clear outside extended superframe
  logic             done_s;
  logic             done_l;
  logic             done_i;
  logic [CNT_W-1:0] cnt_s;
  logic [CNT_W-1:0] cnt_l;
  logic [CNT_W-1:0] cnt_i;
  logic             run;

  assign run = i_esf;

  tnm_err_window #(.PER_S(SHORT_S), .CW(CNT_W)) u_win_short (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (run),
    .i_tick    (o_tick),
    .i_err     (i_crc_err),
    .o_done    (done_s),
    .o_count   (cnt_s)
  );

  tnm_err_window #(.PER_S(LONG_S), .CW(CNT_W)) u_win_long (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (run),
    .i_tick    (o_tick),
    .i_err     (i_crc_err),
    .o_done    (done_l),
    .o_count   (cnt_l)
  );

  tnm_err_window #(.PER_S(INTV_S), .CW(CNT_W)) u_win_intv (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (run),
    .i_tick    (o_tick),
    .i_err     (i_crc_err),
    .o_done    (done_i),
    .o_count   (cnt_i)
  );

  // Sliding sum of the last three interval counts
  logic [CNT_W-1:0] intv1_q;
  logic [CNT_W-1:0] intv2_q;
  logic [SUM_W-1:0] intv_sum;

  assign intv_sum = SUM_W'(cnt_i) + SUM_W'(intv1_q) + SUM_W'(intv2_q);

  // Per-level flags, index 0 is the strictest setting
  logic [THR_N-1:0] lvl_q;
  logic [THR_N-1:0] thr_mask;
  logic             eer_d;
  logic [THR_N-1:0] lvl_hit;
  logic [THR_N-1:0] lvl_upd;

  // A count equal to the limit clears, one above declares
  assign lvl_hit[0] = (cnt_s > LIM_E4);
  assign lvl_hit[1] = (cnt_l > LIM_E5);
  assign lvl_hit[2] = (cnt_l > LIM_E6);
  assign lvl_hit[3] = (cnt_l > LIM_E7);
  assign lvl_hit[4] = (intv_sum > SUM_W'(LIM_E8));
  assign lvl_hit[5] = (intv_sum > SUM_W'(LIM_E9));
  assign lvl_upd    = {done_i, done_i, done_l, done_l, done_l, done_s};

  genvar gi;

  // Each flag holds its verdict until its own period ends again
  generate
    for (gi = 0; gi < THR_N; gi++)
    begin : g_lvl
      always_ff @(posedge i_mclk)
      begin
        if (i_sys_rst || (i_ce && !run))
          lvl_q[gi] <= 1'b0;
        else if (i_ce && lvl_upd[gi])
          lvl_q[gi] <= lvl_hit[gi];
      end
    end
  endgenerate

  // Interval history; after leaving extended superframe the sum restarts from fewer
  // than three intervals rather than trusting stale counts
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || (i_ce && !run))
    begin
      intv1_q <= '0;
      intv2_q <= '0;
    end
    else if (i_ce && done_i)
    begin
      intv1_q <= cnt_i;
      intv2_q <= intv1_q;
    end
  end

  // A looser setting also honours every stricter level
  generate
    for (gi = 0; gi < THR_N; gi++)
    begin : g_mask
      assign thr_mask[gi] = (int'(o_thresh) >= gi);
    end
  endgenerate

  assign eer_d = run && |(lvl_q & thr_mask);

  // Alarm events on condition onset
  logic [ALM_N-1:0] cond;
  logic [ALM_N-1:0] cond_q;
  logic [ALM_N-1:0] evt_d;

  assign cond  = {eer_d, i_yellow, i_ais, i_oof, i_los};
  assign evt_d = cond & ~cond_q & o_alarm_en;

  // Configuration copy; a disabled bit also swallows the onset, so a late
  // enable while the condition stands raises nothing
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_alarm_en <= ALM_EN_RST;
      o_thresh   <= THR_RST;
    end
    else if (i_ce && i_cfg_wr)
    begin
      o_alarm_en <= i_alarm_en;
      o_thresh   <= i_thresh;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      cond_q                   <= '0;
      o_alarm_evt              <= '0;
      o_excess_error_rate_cond <= 1'b0;
    end
    else if (i_ce)
    begin
      cond_q                   <= cond;
      o_alarm_evt              <= evt_d;
      o_excess_error_rate_cond <= eer_d;
    end
  end

  // Lowest free slot, found by a priority chain
  logic [SLOT_W-1:0] low_chain [NUM_SLOTS:0];
  logic [SLOT_W-1:0] low_free;

  assign low_chain[NUM_SLOTS] = SLOT_NONE;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_low
      assign low_chain[gi] = i_slot_busy[gi] ? low_chain[gi+1] : SLOT_W'(gi + 1);
    end
  endgenerate
  assign low_free = low_chain[0];

  logic              req_in_range;
  logic              req_free;
  logic              req_ok;
  logic              ddl_on;
  logic [SLOT_W-1:0] req_idx;

  assign ddl_on       = (i_mgmt_link == LINK_DEDICATED);
  assign req_in_range = (i_slot_req >= SLOT_MIN) && (i_slot_req <= SLOT_MAX);
  assign req_idx      = req_in_range ? i_slot_req - SLOT_MIN : '0;
  assign req_free     = !i_slot_busy[req_idx];
  assign req_ok       = ddl_on && req_in_range && req_free;

  // Slot writes are refused outside the dedicated channel mode as well
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_slot_rej <= 1'b0;
    else if (i_ce)
      o_slot_rej <= i_slot_wr && !req_ok;
  end

  // Busy changes after assignment are not rechecked; the slot stays put
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_dedicated_mgmt_channel_slot <= SLOT_NONE;
    else if (i_ce)
    begin
      if (!ddl_on)
        o_dedicated_mgmt_channel_slot <= SLOT_NONE;
      else if (i_slot_wr && req_ok)
        o_dedicated_mgmt_channel_slot <= i_slot_req;
      else if (o_dedicated_mgmt_channel_slot == SLOT_NONE)
        o_dedicated_mgmt_channel_slot <= low_free;
    end
  end
endmodule

// ==== rtl/tnm_pkg.sv ====
// Shared constants and types for the T1 network alarm monitor.
// Assumes a single 25 MHz system clock and synchronous inputs.
package tnm_pkg;

  // Alarm vector bit positions
  localparam int ALM_LOS = 0;
  localparam int ALM_OOF = 1;
  localparam int ALM_AIS = 2;
  localparam int ALM_YEL = 3;
  localparam int ALM_EER = 4;
  localparam int ALM_N   = 5;
  localparam logic [ALM_N-1:0] ALM_EN_RST = 5'h1f;

  // Error-rate threshold choices, strictest first
  typedef enum logic [2:0] {
    THR_E4,
    THR_E5,
    THR_E6,
    THR_E7,
    THR_E8,
    THR_E9
  } tnm_thr_e;
  localparam tnm_thr_e THR_RST = THR_E4;
  localparam int       THR_N   = 6;

  // Management link selection
  typedef enum logic [1:0] {
    LINK_OFF,
    LINK_FACILITY,
    LINK_DEDICATED
  } tnm_link_e;

  // Error count limits; a count above the limit declares the level
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] LIM_E4 = 16'h05ff;
  localparam logic [CNT_W-1:0] LIM_E5 = 16'h0399;
  localparam logic [CNT_W-1:0] LIM_E6 = 16'h005c;
  localparam logic [CNT_W-1:0] LIM_E7 = 16'h0009;
  localparam logic [CNT_W-1:0] LIM_E8 = 16'h0029;
  localparam logic [CNT_W-1:0] LIM_E9 = 16'h0004;

  // Time slots of the dedicated management channel
  localparam int SLOT_W   = 5;
  localparam int NUM_SLOTS = 24;
  localparam logic [SLOT_W-1:0] SLOT_NONE = 5'h00;
  localparam logic [SLOT_W-1:0] SLOT_MIN  = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_MAX  = 5'h18;

  // Timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_MS     = 1000;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int PER_SHORT_S = 10;
  localparam int PER_LONG_S  = 60;
  localparam int PER_INTV_S  = 900;

endpackage

// ==== rtl/tnm_err_window.sv ====
// Counts CRC-6 errors over a fixed number of one-second ticks.
// Assumes i_tick is a one-cycle pulse once per second.
`timescale 1ns/1ps
module tnm_err_window #(
  parameter int PER_S = 10,
  parameter int CW    = 16
) (
  input  wire logic          i_mclk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_ce,
  input  wire logic          i_run,
  input  wire logic          i_tick,
  input  wire logic          i_err,
  output logic               o_done,
  output logic [CW-1:0]      o_count
);
  localparam int SW = $clog2(PER_S + 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(PER_S - 1);

  logic [SW-1:0] sec_q;
  logic [CW-1:0] acc_q;
  logic [CW-1:0] acc_inc;
  logic          last_sec;

  // Saturate rather than wrap so a storm can never look quiet
  assign acc_inc  = (i_err && acc_q != {CW{1'b1}}) ? acc_q + CW'(1) : acc_q;
  assign last_sec = i_tick && (sec_q == SEC_LAST);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst || (i_ce && !i_run))
    begin
      sec_q   <= '0;
      acc_q   <= '0;
      o_done  <= 1'b0;
      o_count <= '0;
    end
    else if (i_ce)
    begin
      o_done <= last_sec;
      if (last_sec)
      begin
        sec_q   <= '0;
        acc_q   <= '0;
        o_count <= acc_inc;
      end
      else
      begin
        acc_q <= acc_inc;
        if (i_tick)
          sec_q <= sec_q + SW'(1);
      end
    end
  end
endmodule

// ==== testbench/tnm_alarm_monitor_chk.sv ====
// Assertions for the T1 network alarm monitor.
// Sees only the top module's ports; attached by bind.
`timescale 1ns/1ps
module tnm_alarm_monitor_chk
  import tnm_pkg::*;
(
  input wire logic                        i_mclk,
  input wire logic                        i_sys_rst,
  input wire logic                        i_ce,
  input wire logic                        i_los,
  input wire logic                        i_ais,
  input wire logic                        i_yellow,
  input wire logic                        i_esf,
  input wire tnm_pkg::tnm_link_e          i_mgmt_link,
  input wire logic                        i_slot_wr,
  input wire logic [tnm_pkg::ALM_N-1:0]   o_alarm_evt,
  input wire logic [tnm_pkg::ALM_N-1:0]   o_alarm_en,
  input wire logic                        o_excess_error_rate_cond,
  input wire logic [tnm_pkg::SLOT_W-1:0]  o_dedicated_mgmt_channel_slot,
  input wire logic                        o_slot_rej
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  los_event_a: assert property ($rose(i_los) && i_ce && o_alarm_en[0] |=> o_alarm_evt[0])
    else $error("los onset gave no event");
  oof_quiet_a: assert property (!o_alarm_en[1] && i_ce |=> !o_alarm_evt[1])
    else $error("disabled oof gave an event");
  ais_event_a: assert property ($rose(i_ais) && i_ce && o_alarm_en[2] |=> o_alarm_evt[2])
    else $error("ais onset gave no event");
  yel_event_a: assert property ($rose(i_yellow) && i_ce && o_alarm_en[3] |=> o_alarm_evt[3])
    else $error("yellow onset gave no event");
  eer_event_a: assert property ($rose(o_excess_error_rate_cond) && $past(o_alarm_en[4])
    |-> o_alarm_evt[4])
    else $error("error rate rise gave no event");
  eer_esf_a: assert property (!i_esf && i_ce |=> !o_excess_error_rate_cond)
    else $error("error rate held without esf");
  slot_range_a: assert property (o_dedicated_mgmt_channel_slot <= SLOT_MAX)
    else $error("slot out of range");
  slot_free_a: assert property (i_mgmt_link != LINK_DEDICATED && i_ce
    |=> o_dedicated_mgmt_channel_slot == SLOT_NONE)
    else $error("slot kept off the dedicated link");
  slot_rej_a: assert property (i_slot_wr && i_ce && i_mgmt_link != LINK_DEDICATED
    |=> o_slot_rej)
    else $error("slot write not refused");
endmodule
bind tnm_alarm_monitor tnm_alarm_monitor_chk tnm_alarm_monitor_chk_inst (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_los(i_los), .i_ais(i_ais),
  .i_yellow(i_yellow), .i_esf(i_esf), .i_mgmt_link(i_mgmt_link), .i_slot_wr(i_slot_wr),
  .o_alarm_evt(o_alarm_evt), .o_alarm_en(o_alarm_en),
  .o_excess_error_rate_cond(o_excess_error_rate_cond),
  .o_dedicated_mgmt_channel_slot(o_dedicated_mgmt_channel_slot), .o_slot_rej(o_slot_rej));

// ==== testbench/tnm_line_model.sv ====
// Line receiver stand-in: CRC-6 error pulses paced by the one-second tick.
// Assumes i_rate stays below the tick period.
`timescale 1ns/1ps
module tnm_line_model (
  input  wire logic       i_mclk,
  input  wire logic       i_tick,
  input  wire logic [9:0] i_rate,
  output logic            o_crc_err
);
  int left;
  initial
  begin
    left = 0;
    o_crc_err = 1'b0;
  end
  // Burst ends before the next tick, so every period sees exactly i_rate errors
  always @(posedge i_mclk)
  begin
    if (i_tick)
      left = int'(i_rate);
    o_crc_err <= #1 (left > 0);
    if (left > 0)
      left = left - 1;
  end
endmodule

// ==== testbench/test_tnm_alarm_monitor.sv ====
// Self-checking bench for the T1 network alarm monitor.
// Assumes a short tick period so the error windows fit in the run.
`timescale 1ns/1ps
module test_tnm_alarm_monitor;
  import tnm_pkg::*;
  localparam int TN = 800;
  logic i_mclk, i_sys_rst, i_ce, i_esf, i_cfg_wr, i_slot_wr, o_cond, o_slot_rej, o_tick, crc, e;
  logic [3:0] cnd;
  logic [4:0] i_alarm_en, o_alarm_evt, o_alarm_en, o_slot, i_slot_req, ev;
  logic [23:0] i_slot_busy;
  logic [9:0] rate;
  tnm_thr_e i_thresh, o_thresh;
  tnm_link_e i_mgmt_link;
  int n_mismatch, n_tests, seed, lo;
  int rates[5] = '{1, 4, 31, 308, 768};
  int lim[6] = '{1535, 921, 92, 9, 41, 4};
  int mul[6] = '{2, 3, 3, 3, 12, 12};
  tnm_alarm_monitor #(.TICK_N(TN), .SHORT_S(2), .LONG_S(3), .INTV_S(4)) tnm_alarm_monitor_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_los(cnd[0]), .i_oof(cnd[1]),
    .i_ais(cnd[2]), .i_yellow(cnd[3]), .i_crc_err(crc), .i_esf(i_esf), .i_cfg_wr(i_cfg_wr),
    .i_alarm_en(i_alarm_en), .i_thresh(i_thresh), .i_mgmt_link(i_mgmt_link),
    .i_slot_wr(i_slot_wr), .i_slot_req(i_slot_req), .i_slot_busy(i_slot_busy),
    .o_alarm_evt(o_alarm_evt), .o_alarm_en(o_alarm_en), .o_thresh(o_thresh),
    .o_excess_error_rate_cond(o_cond), .o_dedicated_mgmt_channel_slot(o_slot),
    .o_slot_rej(o_slot_rej), .o_tick(o_tick));
  tnm_line_model tnm_line_model_inst (.i_mclk(i_mclk), .i_tick(o_tick), .i_rate(rate),
    .o_crc_err(crc));
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk1(input string nm, input logic ex, input logic got);
    chk(nm, {15'h0, ex}, {15'h0, got});
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cfg(input logic [4:0] en, input int t);
    i_alarm_en = en;
    i_thresh = tnm_thr_e'(t);
    i_cfg_wr = 1'b1;
    step(1);
    i_cfg_wr = 1'b0;
    chk("alarm_en", {11'h0, en}, {11'h0, o_alarm_en});
    chk("thresh", 16'(t), {13'h0, o_thresh});
  endtask
  task automatic slot_try(input logic [4:0] s, input logic [4:0] ex, input logic rej);
    i_slot_req = s;
    i_slot_wr = 1'b1;
    step(1);
    i_slot_wr = 1'b0;
    chk("slot", {11'h0, ex}, {11'h0, o_slot});
    chk1("slot_rej", rej, o_slot_rej);
    step(1);
  endtask
  task automatic wait_tick();
    int k;
    k = 0;
    while (o_tick !== 1'b1 && k < TN + 4)
    begin
      step(1);
      k++;
    end
    if (k >= TN + 4)
    begin
      n_mismatch++;
      summarize();
    end
    step(1);
  endtask
  initial
  begin
    seed = 32'h3663;
    n_mismatch = 0;
    n_tests = 0;
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_esf = 1'b0;
    i_cfg_wr = 1'b0;
    i_slot_wr = 1'b0;
    cnd = 4'h0;
    i_alarm_en = 5'h1f;
    i_thresh = THR_E4;
    i_mgmt_link = LINK_OFF;
    i_slot_req = 5'h00;
    i_slot_busy = 24'h000000;
    rate = 10'h000;
    step(2);
    i_sys_rst = 1'b0;
    chk("alarm_en", {11'h0, ALM_EN_RST}, {11'h0, o_alarm_en});
    // Clock enable low freezes the onset history; the event comes on release
    i_ce = 1'b0;
    cnd[0] = 1'b1;
    step(2);
    chk1("evt_ce", 1'b0, o_alarm_evt[0]);
    i_ce = 1'b1;
    step(1);
    chk1("evt_ce", 1'b1, o_alarm_evt[0]);
    cnd[0] = 1'b0;
    step(1);
    for (int k = 0; k < 8; k++)
    begin
      cfg(5'($random(seed)), 0);
      cnd[k%4] = 1'b1;
      ev = 5'h00;
      ev[k%4] = i_alarm_en[k%4];
      step(1);
      chk("evt", {11'h0, ev}, {11'h0, o_alarm_evt});
      cnd[k%4] = 1'b0;
      step(1);
    end
    // Slot 3 always taken and slot 24 always free
    i_slot_busy = (24'($random(seed)) | 24'h000004) & 24'h7fffff;
    lo = 0;
    for (int s = 24; s >= 1; s--)
      if (!i_slot_busy[s-1])
        lo = s;
    i_mgmt_link = LINK_DEDICATED;
    step(3);
    chk("slot", 16'(lo), {11'h0, o_slot});
    slot_try(5'h03, 5'(lo), 1'b1);
    slot_try(5'h18, 5'h18, 1'b0);
    slot_try(5'h00, 5'h18, 1'b1);
    slot_try(5'h19, 5'h18, 1'b1);
    i_mgmt_link = LINK_OFF;
    step(2);
    chk("slot", 16'h0, {11'h0, o_slot});
    slot_try(5'h05, 5'h00, 1'b1);
    for (int r = 0; r < 5; r++)
    begin
      rate = 10'(rates[r]);
      i_esf = 1'b0;
      step(2);
      chk1("eer", 1'b0, o_cond);
      i_esf = 1'b1;
      repeat (16) wait_tick();
      for (int t = 0; t < 6; t++)
      begin
        cfg(5'h1f, t);
        step(3);
        e = 1'b0;
        for (int l = 0; l <= t; l++)
          if (mul[l] * rates[r] > lim[l])
            e = 1'b1;
        chk1("eer", e, o_cond);
      end
    end
    summarize();
  end
endmodule
